// file: src/bcpm_regs.vh
`ifndef BCPM_REGS_VH
`define BCPM_REGS_VH
// charge modes
`define BCPM_MODE_IDLE     3'h0
`define BCPM_MODE_FAST     3'h1
`define BCPM_MODE_TOPUP    3'h2
`define BCPM_MODE_FLOAT    3'h3
`define BCPM_MODE_TERM     3'h4
// temperature limits, signed 0.1 degC units
`define BCPM_T_FAST_LO     12'sd100
`define BCPM_T_FAST_HI     12'sd270
`define BCPM_T_START_HI    12'sd400
`define BCPM_T_END_MIN     12'sd300
`define BCPM_T_ABS_LO      12'sd100
`define BCPM_T_ABS_HI      12'sd550
// rise rate in 0.1 degC per minute: 0.7 full current, 0.6 reduced
`define BCPM_RATE_FULL     12'sd7
`define BCPM_RATE_LOW      12'sd6
// discharge threshold, amp-seconds
`define BCPM_DISCH_AS      16'd200
// voltages in mV
`define BCPM_V_DROP_MV     16'd50
`define BCPM_V_ALARM_MV    16'd11200
`define BCPM_V_SHUT_MV     16'd11000
`define BCPM_V_CUT_MV      16'd10800
// gauge warning, minutes left
`define BCPM_GAUGE_WARN    16'd30
// times in seconds
`define BCPM_FAST_MAX_S    32'd9360
`define BCPM_TOPUP_S       32'd10800
`define BCPM_SHUT_DELAY_S  32'd300
`define BCPM_FLOAT_PER_S   8'd60
`define BCPM_FLOAT_ON_S    8'd1
// top-up duty: 0.4A of 2A is 1 of 5 seconds on
`define BCPM_TOPUP_PER_S   8'd5
`define BCPM_TOPUP_ON_S    8'd1
// clock rate and seconds tick
`define BCPM_CLK_HZ        100000000
`define BCPM_SEC_CYCLES    (`BCPM_CLK_HZ / 1)
`endif

// file: src/bcpm_power_manager.v
`timescale 1ns/1ps
`default_nettype none
`include "bcpm_regs.vh"
module bcpm_power_manager #(
  parameter SEC_CYCLES   = `BCPM_SEC_CYCLES,
  parameter FAST_MAX_S   = `BCPM_FAST_MAX_S,
  parameter TOPUP_S      = `BCPM_TOPUP_S,
  parameter SHUT_DELAY_S = `BCPM_SHUT_DELAY_S
) (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rstn,
  // battery measurements
  input  wire signed [11:0] batt_temp,
  input  wire [15:0] batt_mv,
  input  wire [15:0] disch_as,
  input  wire        load_reduced,
  input  wire [15:0] gauge_min,
  input  wire        main_power_ok,
  // switches and watchdog
  input  wire        sw_a,
  input  wire        sw_b,
  input  wire        wdog_alarm,
  // main processor side
  input  wire        cmd_valid,
  input  wire [7:0]  cmd_code,
  input  wire        off_req,
  output reg         rsp_valid,
  output reg  [31:0] rsp_data,
  output reg         sw_event,
  // power and charge controls
  output reg         sys_power,
  output reg         charger_on,
  output reg  [2:0]  charge_mode,
  output reg         sram_backup,
  output reg         warn_low,
  output reg         warn_tone,
  output reg         alarm_low,
  output reg         pump_inhibit,
  output reg         backup_speaker,
  output reg         load_cutoff
);

  // seconds tick
  reg  [31:0] sec_cnt;
  wire        tick = (sec_cnt == SEC_CYCLES - 1);
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sec_cnt <= 32'h0;
    end else if (tick) begin
      sec_cnt <= 32'h0;
    end else begin
      sec_cnt <= sec_cnt + 32'h1;
    end
  end

  // duty window helper: on for first on_s of every per_s seconds
  function duty_on;
    input [7:0] phase;
    input [7:0] on_s;
    begin
      duty_on = (phase < on_s);
    end
  endfunction

  // temperature window helpers
  wire t_abs_bad  = (batt_temp < `BCPM_T_ABS_LO) || (batt_temp > `BCPM_T_ABS_HI);
  wire t_start_ok = (batt_temp >= `BCPM_T_ABS_LO) && (batt_temp <= `BCPM_T_START_HI);
  wire t_fast_ok  = (batt_temp >= `BCPM_T_FAST_LO) && (batt_temp <= `BCPM_T_FAST_HI);

  // charge state
  reg  [31:0]        phase_s;
  reg  [31:0]        on_s;
  reg  [7:0]         win;
  reg  [15:0]        v_peak;
  reg  signed [11:0] t_start;
  reg  [31:0]        min_base;
  wire [7:0]         win_per = (charge_mode == `BCPM_MODE_FLOAT) ? `BCPM_FLOAT_PER_S
                                                                  : `BCPM_TOPUP_PER_S;
  // rise since start, compared against rate times elapsed minutes
  wire signed [31:0] rise   = $signed({{20{batt_temp[11]}}, batt_temp})
                              - $signed({{20{t_start[11]}}, t_start});
  wire [11:0]        rate   = load_reduced ? `BCPM_RATE_LOW : `BCPM_RATE_FULL;
  wire [31:0]        mins   = phase_s / 32'd60;
  wire [31:0]        need   = mins * {20'h0, rate};
  wire               rate_hit = (mins != 32'h0) && (rise >= $signed(need));
  wire               fast_end = ((batt_temp >= `BCPM_T_END_MIN) && rate_hit)
                                || ({1'b0, batt_mv} + `BCPM_V_DROP_MV <= {1'b0, v_peak})
                                || (phase_s > FAST_MAX_S);

  // charge cycle state machine
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      charge_mode <= `BCPM_MODE_IDLE;
      phase_s     <= 32'h0;
      on_s        <= 32'h0;
      win         <= 8'h0;
      v_peak      <= 16'h0;
      t_start     <= 12'sh0;
      min_base    <= 32'h0;
    end else begin
      case (charge_mode)
        `BCPM_MODE_IDLE: begin
          if (t_fast_ok && t_start_ok && (disch_as > `BCPM_DISCH_AS)) begin
            charge_mode <= `BCPM_MODE_FAST;
            phase_s     <= 32'h0;
            v_peak      <= batt_mv;
            t_start     <= batt_temp;
          end
        end
        `BCPM_MODE_FAST: begin
          if (t_abs_bad) begin
            charge_mode <= `BCPM_MODE_TERM;
          end else if (fast_end) begin
            charge_mode <= `BCPM_MODE_TOPUP;
            phase_s     <= 32'h0;
            on_s        <= 32'h0;
            win         <= 8'h0;
          end else begin
            if (batt_mv > v_peak) begin
              v_peak <= batt_mv;
            end
            if (tick) begin
              phase_s <= phase_s + 32'h1;
            end
          end
        end
        `BCPM_MODE_TOPUP: begin
          if (t_abs_bad) begin
            charge_mode <= `BCPM_MODE_TERM;
          end else if (on_s >= TOPUP_S) begin
            charge_mode <= `BCPM_MODE_FLOAT;
            win         <= 8'h0;
          end else if (tick) begin
            if (charger_on) begin
              on_s <= on_s + 32'h1;
            end
            win <= (win == win_per - 8'h1) ? 8'h0 : win + 8'h1;
          end
        end
        `BCPM_MODE_FLOAT: begin
          if (t_abs_bad) begin
            charge_mode <= `BCPM_MODE_TERM;
          end else if (t_fast_ok && (disch_as > `BCPM_DISCH_AS)) begin
            charge_mode <= `BCPM_MODE_FAST;
            phase_s     <= 32'h0;
            v_peak      <= batt_mv;
            t_start     <= batt_temp;
          end else if (tick) begin
            win <= (win == win_per - 8'h1) ? 8'h0 : win + 8'h1;
          end
        end
        `BCPM_MODE_TERM: begin
          if (t_start_ok) begin
            charge_mode <= `BCPM_MODE_IDLE;
          end
        end
        default: begin
          charge_mode <= `BCPM_MODE_IDLE;
        end
      endcase
    end
  end

  // charger drive per mode
  reg next_charger_on;
  always @* begin
    case (charge_mode)
      `BCPM_MODE_FAST:  next_charger_on = 1'b1;
      `BCPM_MODE_TOPUP: next_charger_on = duty_on(win, `BCPM_TOPUP_ON_S);
      `BCPM_MODE_FLOAT: next_charger_on = duty_on(win, `BCPM_FLOAT_ON_S);
      default:          next_charger_on = 1'b0;
    endcase
    if (t_abs_bad) begin
      next_charger_on = 1'b0;
    end
  end

  // switch edge detect
  reg  sw_q;
  wire sw_any   = sw_a | sw_b;
  wire sw_press = sw_any & ~sw_q;

  // press decode; a refused press while off is not reported
  wire press_cut = sw_press & wdog_alarm;
  wire press_on  = sw_press & ~sys_power & ~load_cutoff;
  wire press_fwd = sw_press & sys_power;

  // battery alarm timer
  reg [31:0] alarm_s;

  // power sequencing and alarms
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sw_q           <= 1'b0;
      sys_power      <= 1'b0;
      sw_event       <= 1'b0;
      charger_on     <= 1'b0;
      sram_backup    <= 1'b0;
      warn_low       <= 1'b0;
      warn_tone      <= 1'b0;
      alarm_low      <= 1'b0;
      pump_inhibit   <= 1'b0;
      backup_speaker <= 1'b0;
      load_cutoff    <= 1'b0;
      alarm_s        <= 32'h0;
    end else begin
      sw_q        <= sw_any;
      charger_on  <= next_charger_on;
      sram_backup <= ~main_power_ok;
      sw_event    <= 1'b0;
      if (press_cut) begin
        sys_power <= 1'b0;
      end else if (press_on) begin
        sys_power <= 1'b1;
        sw_event  <= 1'b1;
      end else if (press_fwd) begin
        sw_event  <= 1'b1;
      end else if (off_req && sys_power) begin
        sys_power <= 1'b0;
      end else if (backup_speaker && alarm_s >= SHUT_DELAY_S) begin
        sys_power <= 1'b0;
      end else if (load_cutoff) begin
        sys_power <= 1'b0;
      end
      // low battery levels, cleared when power is off; load_cutoff clears only with main_power_ok and batt_mv above cut
      warn_low  <= sys_power && (gauge_min <= `BCPM_GAUGE_WARN);
      warn_tone <= sys_power && (gauge_min <= `BCPM_GAUGE_WARN);
      if (!sys_power) begin
        alarm_low      <= 1'b0;
        pump_inhibit   <= 1'b0;
        backup_speaker <= 1'b0;
        alarm_s        <= 32'h0;
      end else begin
        if (batt_mv <= `BCPM_V_ALARM_MV) begin
          alarm_low    <= 1'b1;
          pump_inhibit <= 1'b1;
        end
        if (batt_mv <= `BCPM_V_SHUT_MV) begin
          backup_speaker <= 1'b1;
        end
        if (alarm_low && tick) begin
          alarm_s <= alarm_s + 32'h1;
        end
      end
      if (batt_mv <= `BCPM_V_CUT_MV) begin
        load_cutoff <= 1'b1;
      end else if (main_power_ok) begin
        load_cutoff <= 1'b0;
      end
    end
  end

  // status word returned with each answer
  wire [31:0] status_word = {cmd_code,
                             charge_mode,
                             charger_on,
                             sys_power,
                             warn_low,
                             alarm_low,
                             backup_speaker,
                             load_cutoff,
                             sram_backup,
                             batt_mv[11:0],
                             2'h0};

  // command answer with status word
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rsp_valid <= 1'b0;
      rsp_data  <= 32'h0;
    end else begin
      rsp_valid <= cmd_valid;
      if (cmd_valid) begin
        rsp_data <= status_word;
      end
    end
  end

endmodule
`default_nettype wire

// file: test/bcpm_checker_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "bcpm_regs.vh"
module bcpm_checker (
  // clock and reset
  input wire logic               clk_sys,
  input wire logic               rstn,
  // inputs seen
  input wire logic signed [11:0] batt_temp,
  input wire logic [15:0]        batt_mv,
  input wire logic               sw_a,
  input wire logic               sw_b,
  input wire logic               wdog_alarm,
  input wire logic               cmd_valid,
  input wire logic [7:0]         cmd_code,
  input wire logic               off_req,
  // outputs seen
  input wire logic               rsp_valid,
  input wire logic [31:0]        rsp_data,
  input wire logic               sw_event,
  input wire logic               sys_power,
  input wire logic               charger_on,
  input wire logic [2:0]         charge_mode,
  input wire logic               alarm_low,
  input wire logic               load_cutoff
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // press is a rising edge of either switch
  logic sw_d;
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn) sw_d <= 1'b0;
    else sw_d <= sw_a | sw_b;
  wire logic press = (sw_a | sw_b) & ~sw_d;
  wire logic act = charge_mode inside {`BCPM_MODE_FAST, `BCPM_MODE_TOPUP, `BCPM_MODE_FLOAT};
  // the assertions
  a_rsp_answer: assert property (
    cmd_valid |=> rsp_valid && rsp_data[31:24] == $past(cmd_code)) else $error("bad answer");
  a_fast_on: assert property (
    charge_mode == `BCPM_MODE_FAST ##1 charge_mode == `BCPM_MODE_FAST |-> charger_on)
    else $error("fast charge not continuous");
  a_temp_stop: assert property (
    act && (batt_temp < `BCPM_T_ABS_LO || batt_temp > `BCPM_T_ABS_HI)
    |=> charge_mode == `BCPM_MODE_TERM) else $error("no temperature stop");
  a_wdog_cut: assert property (
    sys_power && wdog_alarm && press |=> !sys_power) else $error("power kept in alarm");
  a_press_on: assert property (
    !sys_power && press && !wdog_alarm && !load_cutoff |=> sys_power && sw_event)
    else $error("press did not power up");
  a_press_fwd: assert property (
    sys_power && press && !wdog_alarm |=> sw_event) else $error("press not forwarded");
  a_alarm_set: assert property (
    sys_power && batt_mv <= `BCPM_V_ALARM_MV && batt_mv > `BCPM_V_CUT_MV
    |-> ##[0:2] alarm_low) else $error("no low alarm");
  a_cut_set: assert property (
    sys_power && batt_mv <= `BCPM_V_CUT_MV |-> ##[0:2] load_cutoff) else $error("no cutoff");
  a_off_remove: assert property (
    sys_power && off_req && !press |=> !sys_power) else $error("off request ignored");
  a_cut_refuse: assert property (
    !sys_power && load_cutoff && press |=> !sys_power && !sw_event)
    else $error("press honoured under cutoff");
endmodule
bind bcpm_power_manager bcpm_checker u_chk (
  .clk_sys(clk_sys), .rstn(rstn), .batt_temp(batt_temp), .batt_mv(batt_mv), .sw_a(sw_a),
  .sw_b(sw_b), .wdog_alarm(wdog_alarm), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
  .off_req(off_req), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .sw_event(sw_event),
  .sys_power(sys_power), .charger_on(charger_on), .charge_mode(charge_mode),
  .alarm_low(alarm_low), .load_cutoff(load_cutoff));
`default_nettype wire

// file: test/bcpm_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module bcpm_host_model (
  // clock
  input wire logic   clk_sys,
  // requests to the controller
  output logic       cmd_valid,
  output logic [7:0] cmd_code,
  output logic       off_req
);
  // idle at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 8'h00;
    off_req = 1'b0;
  end
  // one command; code flips once released
  task automatic send(input logic [7:0] code);
    @(posedge clk_sys) #1;
    cmd_valid = 1'b1;
    cmd_code = code;
    @(posedge clk_sys) #1;
    cmd_valid = 1'b0;
    cmd_code = ~code;
  endtask
  // power-off request pulse
  task automatic power_off;
    @(posedge clk_sys) #1;
    off_req = 1'b1;
    @(posedge clk_sys) #1;
    off_req = 1'b0;
  endtask
endmodule
`default_nettype wire

// file: test/bcpm_power_manager_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "bcpm_regs.vh"
module bcpm_power_manager_tb;
  localparam integer SEC = 10, SD = 5;
  localparam logic [12:0] LC = 13'h0001, SP = 13'h0002, AL = 13'h000C, WL = 13'h0030;
  localparam logic [12:0] SR = 13'h0040, EV = 13'h0080, CH = 13'h0100, PW = 13'h0200;
  localparam logic [12:0] MD = 13'h1C00, Z = 13'h0000;
  // stimulus
  logic clk_sys = 1'b0, rstn = 1'b0, load_reduced = 1'b0, main_power_ok = 1'b1;
  logic sw_a = 1'b0, sw_b = 1'b0, wdog_alarm = 1'b0;
  logic signed [11:0] batt_temp = 12'sh0C8;
  logic [15:0] batt_mv = 16'h3200, disch_as = 16'h0000, gauge_min = 16'h0064;
  // outputs
  logic cmd_valid, off_req, rsp_valid, sw_event, sys_power, charger_on, sram_backup;
  logic warn_low, warn_tone, alarm_low, pump_inhibit, backup_speaker, load_cutoff;
  logic [7:0] cmd_code, code;
  logic [31:0] rsp_data;
  logic [2:0] charge_mode;
  wire logic [12:0] obs = {charge_mode, sys_power, charger_on, sw_event, sram_backup,
    warn_low, warn_tone, alarm_low, pump_inhibit, backup_speaker, load_cutoff};
  wire logic [20:0] rsp_f = {rsp_data[31:24], rsp_data[19], rsp_data[13:2]};
  integer n_fail = 0, n_checks = 0, seed = 99745;
  logic [7:0] exp_q[$];
  bcpm_power_manager #(.SEC_CYCLES(SEC), .FAST_MAX_S(400), .TOPUP_S(4), .SHUT_DELAY_S(SD))
    DUT (.clk_sys(clk_sys), .rstn(rstn), .batt_temp(batt_temp), .batt_mv(batt_mv),
         .disch_as(disch_as), .load_reduced(load_reduced), .gauge_min(gauge_min),
         .main_power_ok(main_power_ok), .sw_a(sw_a), .sw_b(sw_b), .wdog_alarm(wdog_alarm),
         .cmd_valid(cmd_valid), .cmd_code(cmd_code), .off_req(off_req),
         .rsp_valid(rsp_valid), .rsp_data(rsp_data), .sw_event(sw_event),
         .sys_power(sys_power), .charger_on(charger_on), .charge_mode(charge_mode),
         .sram_backup(sram_backup), .warn_low(warn_low), .warn_tone(warn_tone),
         .alarm_low(alarm_low), .pump_inhibit(pump_inhibit),
         .backup_speaker(backup_speaker), .load_cutoff(load_cutoff));
  bcpm_host_model host (.clk_sys(clk_sys), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .off_req(off_req));
  always #5 clk_sys = ~clk_sys;
  function automatic logic [12:0] md(input logic [2:0] m);
    md = {m, 10'h000};
  endfunction
  task automatic tick;
    @(posedge clk_sys) #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // bounded wait for masked outputs
  task automatic wt(input logic [12:0] m, input logic [12:0] v, input integer lim);
    for (integer i = 0; i < lim && (obs & m) !== v; i++) tick;
    if ((obs & m) !== v) begin
      n_fail++;
      give_verdict;
    end else chk(obs & m, v);
  endtask
  // press one switch, wait, release
  task automatic sw(input logic b, input logic [12:0] m, input logic [12:0] v);
    tick;
    sw_a = !b;
    sw_b = b;
    wt(m, v, 4);
    tick;
    sw_a = 1'b0;
    sw_b = 1'b0;
  endtask
  // charger on-cycles over a window
  task automatic cnt(input integer n, input integer e);
    integer k = 0;
    repeat (n) begin tick; k += charger_on; end
    chk(k, e);
  endtask
  // answers against queued codes
  always @(posedge clk_sys)
    if (rsp_valid === 1'b1) chk(rsp_f, {exp_q.pop_front(), 1'b1, batt_mv[11:0]});
  initial begin
    repeat (16) @(posedge clk_sys);
    #1 rstn = 1'b1;
    sw(1'b0, PW | EV, PW | EV);
    repeat (6) begin
      code = 8'($random(seed));
      exp_q.push_back(code);
      host.send(code);
    end
    sw(1'b1, PW | EV, PW | EV);
    host.power_off;
    wt(PW, Z, 4);
    sw(1'b0, PW, PW);
    wdog_alarm = 1'b1;
    sw(1'b1, PW, Z);
    wdog_alarm = 1'b0;
    main_power_ok = 1'b0;
    wt(SR, SR, 3);
    main_power_ok = 1'b1;
    disch_as = 16'h012C;
    wt(MD | CH, md(`BCPM_MODE_FAST) | CH, 5);
    batt_mv = 16'h3264;
    repeat (3) tick;
    batt_mv = 16'h323C;
    cnt(4, 4);
    chk(charge_mode, `BCPM_MODE_FAST);
    batt_mv = 16'h3232;
    disch_as = 16'h0000;
    wt(MD, md(`BCPM_MODE_TOPUP), 4);
    cnt(10 * SEC, 2 * SEC);
    wt(MD, md(`BCPM_MODE_FLOAT), 25 * SEC);
    cnt(60 * SEC, SEC);
    batt_temp = 12'sh258;
    wt(MD | CH, md(`BCPM_MODE_TERM), 4);
    batt_temp = 12'sh15E;
    wt(MD, md(`BCPM_MODE_IDLE), 4);
    disch_as = 16'h012C;
    cnt(5, 0);
    batt_temp = 12'sh10E;
    wt(MD | CH, md(`BCPM_MODE_FAST) | CH, 5);
    disch_as = 16'h0000;
    repeat (310 * SEC) tick;
    batt_temp = 12'sh12C;
    repeat (5 * SEC) tick;
    chk(charge_mode, `BCPM_MODE_FAST);
    load_reduced = 1'b1;
    wt(MD, md(`BCPM_MODE_TOPUP), 4);
    load_reduced = 1'b0;
    batt_temp = 12'sh0FA;
    wt(MD, md(`BCPM_MODE_FLOAT), 25 * SEC);
    disch_as = 16'h012C;
    wt(MD, md(`BCPM_MODE_FAST), 4);
    disch_as = 16'h0000;
    repeat (395 * SEC) tick;
    chk(charge_mode, `BCPM_MODE_FAST);
    wt(MD, md(`BCPM_MODE_TOPUP), 10 * SEC);
    disch_as = 16'h0000;
    sw(1'b0, PW, PW);
    gauge_min = 16'h001E;
    wt(WL, WL, 4);
    batt_mv = 16'h2BC0;
    wt(AL, AL, 4);
    batt_mv = 16'h2AF8;
    wt(SP, SP, 4);
    repeat ((SD - 2) * SEC) tick;
    chk(sys_power, 1'b1);
    wt(PW, Z, 3 * SEC + 4);
    sw(1'b0, PW, PW);
    batt_mv = 16'h29CC;
    wt(LC, LC, 4);
    wt(PW, Z, 4);
    sw(1'b1, PW, Z);
    repeat (3) tick;
    chk(sys_power, 1'b0);
    chk(exp_q.size(), 32'h0);
    give_verdict;
  end
endmodule
`default_nettype wire
